// [rtl/itp_pkg.sv]
// itp_pkg: constants shared by the interrupt and trap prioritizer
// assumes a 32-bit APB slave with byte addresses and one word per register
package itp_pkg;

   // source table and user priorities
   localparam int                  NUM_SRC      = 54;
   localparam int                  SRC_IDX_W    = 6;
   localparam int                  PRIO_W       = 3;
   localparam int                  NIB_W        = 4;
   localparam int                  NIB_PER_WORD = 8;
   localparam logic [NUM_SRC-1:0]  RESERVED_SRC = 54'h3f_f980_0000_0000; // 39-40, 43-53
   localparam int                  VEC_W        = 6;
   localparam logic [VEC_W-1:0]    SRC_VEC_BASE = 6'h08;
   localparam int                  LVL_W        = 4;

   // traps, index order is increasing priority
   localparam int                  NUM_TRAP      = 4;
   localparam int                  TRAP_IDX_W    = 2;
   localparam int                  TRAP_MATH     = 0;
   localparam int                  TRAP_ADDR     = 1;
   localparam int                  TRAP_STACK    = 2;
   localparam int                  TRAP_OSC      = 3;
   localparam logic [LVL_W-1:0]    TRAP_LVL_BASE = 4'hb;
   localparam logic [VEC_W-1:0]    TRAP_VEC_BASE = 6'h01;

   // register map
   localparam int                  ADDR_W       = 8;
   localparam int                  DATA_W       = 32;
   localparam int                  BYTE_SHIFT   = 2;
   localparam logic [ADDR_W-1:0]   OFS_PRIO_END = 8'h1c;
   localparam logic [ADDR_W-1:0]   OFS_CTRL     = 8'h20;
   localparam logic [ADDR_W-1:0]   OFS_STATUS   = 8'h24;
   localparam logic [ADDR_W-1:0]   OFS_CAUSE    = 8'h28;

   // control register fields
   localparam int                  CTL_W        = 4;
   localparam int                  CTL_NEST_DIS = 0;
   localparam int                  CTL_ALT_TBL  = 1;
   localparam int                  CTL_OVF31_EN = 2;
   localparam int                  CTL_OVF39_EN = 3;

   // reset cause register fields
   localparam int                  CAUSE_W      = 5;
   localparam int                  CAUSE_WDT    = 0;
   localparam int                  CAUSE_UNINIT = 1;
   localparam int                  CAUSE_ILLEGAL = 2;
   localparam int                  CAUSE_BROWN  = 3;
   localparam int                  CAUSE_LOCK   = 4;

endpackage : itp_pkg

// [rtl/itp_prioritizer.sv]
// itp_prioritizer: arbitrates peripheral requests and processor traps
// assumes core-side signals run on core_clk; registers sit behind APB
//
// Contract
// RL1 - 3-bit priority per source, nibble bit 3 zero
// RL2 - priority 0 lowest, 7 highest
// RL3 - natural order only breaks equal-priority ties
// RL4 - natural rank equals interrupt number 0..53
// RL5 - vector number is interrupt number plus eight
// RL6 - fixed source table, reserved numbers never request
// RL7 - reset restarts core at zero, no vectoring
// RL8 - error conditions routed to device reset
// RL9 - uninitialised pointer register use resets device
// RL10 - executed unused opcode traps, flushed one not; code takes a device reset (CAUSE_ILLEGAL) instead of a trap
// RL11 - simultaneous trap conditions cause lockout reset
// RL12 - traps non-maskable with fixed priority
// RL13 - invalid trap vector raises address error trap
// RL14 - offending instruction completes before trap processing
// RL15 - trap levels 8..15, level top bit set
// RL16 - level 7 masks interrupts, traps still serviced
// RL17 - traps nest, ordered by increasing priority
// RL18 - divide by zero takes math error trap
// RL19 - enabled bit-31 overflow without guard bits traps
// RL20 - enabled bit-39 overflow without saturation traps
// RL21 - oversized shift amount takes math error trap
// RL22 - priority zero source never interrupts
// RL23 - interrupt only above current cpu priority level
// RL24 - nesting disable blocks interrupts while servicing
// RL25 - alternate table select moves all vector fetches
// RL26 - highest priority wins, then lowest number
`timescale 1ns/100ps
`default_nettype none

module itp_prioritizer
   import itp_pkg::*;
(
   // clock and synchronous reset
   input  wire logic                            core_clk,
   input  wire logic                            rst,
   // apb slave
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [itp_pkg::ADDR_W-1:0]      paddr,
   input  wire logic [itp_pkg::DATA_W-1:0]      pwdata,
   output logic      [itp_pkg::DATA_W-1:0]      prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   // peripheral request flags, enables already applied
   input  wire logic [itp_pkg::NUM_SRC-1:0]     srcReq,
   // core state
   input  wire logic [itp_pkg::LVL_W-1:0]       cpu_priority_level,
   input  wire logic                            inService,
   input  wire logic                            instrDone,
   input  wire logic                            trapAck,
   // math error conditions
   input  wire logic                            divByZero,
   input  wire logic [1:0]                      accOvf31,
   input  wire logic                            guardBitsInUse,
   input  wire logic [1:0]                      accOvf39,
   input  wire logic                            saturationOff,
   input  wire logic                            shiftTooFar,
   // other trap conditions
   input  wire logic                            addrError,
   input  wire logic                            badTrapVector,
   input  wire logic                            stackError,
   input  wire logic                            oscFail,
   // reset-causing conditions
   input  wire logic                            wdtTimeout,
   input  wire logic                            uninitPointer,
   input  wire logic                            illegalExec,
   input  wire logic                            illegalFlushed,
   input  wire logic                            brownout_reset,
   // to the core
   output logic                                 irqReq,
   output logic      [itp_pkg::VEC_W-1:0]       irqVector,
   output logic      [itp_pkg::LVL_W-1:0]       irqLevel,
   output logic                                 trapReq,
   output logic      [itp_pkg::VEC_W-1:0]       trapVector,
   output logic      [itp_pkg::LVL_W-1:0]       trapLevel,
   output logic                                 alternate_table_select,
   output logic                                 coreReset
);
   import itp_pkg::*;

   typedef logic [ADDR_W-BYTE_SHIFT-1:0] itp_word_t;

   typedef struct packed {
      logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
      logic [CTL_W-1:0]               ctrl;
      logic [CAUSE_W-1:0]             cause;
      logic [NUM_TRAP-1:0]            trapPend;
      logic                           trapReq;
      logic [TRAP_IDX_W-1:0]          trapIdx;
      logic [VEC_W-1:0]               trapVector;
      logic [LVL_W-1:0]               trapLevel;
      logic                           irqReq;
      logic [VEC_W-1:0]               irqVector;
      logic [LVL_W-1:0]               irqLevel;
      logic                           altTable;
      logic                           coreReset;
      logic                           pready;
      logic                           pslverr;
      logic [DATA_W-1:0]              prdata;
   } itp_state_s;

   itp_state_s                  st_ff;
   itp_state_s                  nxt_st;

   // winner of source arbitration: {found, level, index}
   logic [SRC_IDX_W+PRIO_W:0]   srcPick;
   logic                        srcFound;
   logic [PRIO_W-1:0]           srcLevel;
   logic [SRC_IDX_W-1:0]        srcIdx;
   logic                        mathHit;
   logic [NUM_TRAP-1:0]         newTrap;
   logic                        lockout;
   logic [CAUSE_W-1:0]          causeSet;
   logic                        nestBlock;
   logic                        setupPhase;
   logic                        wrAccess;
   itp_word_t                   wordIdx;
   logic [DATA_W-1:0]           rdWord;
   logic                        trapFound;
   logic [TRAP_IDX_W-1:0]       trapPick;

   // priority search: a strictly higher level always wins, and scanning
   // from the top index down with >= lets the lower number win a tie
   function automatic logic [SRC_IDX_W+PRIO_W:0] pickSource(
      input logic [NUM_SRC-1:0]             req,
      input logic [NUM_SRC-1:0][PRIO_W-1:0] prio,
      input logic [LVL_W-1:0]               lvl
   );
      logic                   found;
      logic [PRIO_W-1:0]      best;
      logic [SRC_IDX_W-1:0]   idx;
      found = 1'b0;
      best  = '0;
      idx   = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         if (req[i] && prio[i] != '0 && {1'b0, prio[i]} > lvl && prio[i] >= best) // see RL22
         begin
            found = 1'b1; // see RL23
            best  = prio[i]; // see RL26
            idx   = SRC_IDX_W'(i); // see RL3
         end
      end
      return {found, best, idx};
   endfunction : pickSource

   // level of a trap follows its fixed index
   function automatic logic [LVL_W-1:0] trapLevelOf(input logic [TRAP_IDX_W-1:0] idx);
      return TRAP_LVL_BASE + LVL_W'(idx); // see RL15
   endfunction : trapLevelOf

   // apb phases
   assign setupPhase = psel && !penable;
   assign wrAccess   = psel && penable && st_ff.pready && pwrite;
   assign wordIdx    = paddr[ADDR_W-1:BYTE_SHIFT];

   // reserved numbers are stripped before arbitration
   assign srcPick  = pickSource(srcReq & ~RESERVED_SRC, st_ff.prio, cpu_priority_level); // see RL6
   assign srcFound = srcPick[SRC_IDX_W+PRIO_W];
   assign srcLevel = srcPick[SRC_IDX_W +: PRIO_W];
   assign srcIdx   = srcPick[SRC_IDX_W-1:0];

   // nesting disable only bites while the core is inside a handler
   assign nestBlock = st_ff.ctrl[CTL_NEST_DIS] && inService; // see RL24

   // math error conditions, overflow ones gated by their enables
   assign mathHit = divByZero // see RL18
                  || (st_ff.ctrl[CTL_OVF31_EN] && !guardBitsInUse && |accOvf31) // see RL19
                  || (st_ff.ctrl[CTL_OVF39_EN] && saturationOff && |accOvf39) // see RL20
                  || shiftTooFar; // see RL21

   // trap conditions seen this cycle, index order = priority order
   always_comb
   begin
      newTrap[TRAP_MATH]  = mathHit;
      newTrap[TRAP_ADDR]  = addrError || badTrapVector; // see RL13
      newTrap[TRAP_STACK] = stackError;
      newTrap[TRAP_OSC]   = oscFail;
   end

   // more than one trap in the same cycle cannot be vectored sensibly
   assign lockout = (newTrap & (newTrap - NUM_TRAP'(1))) != '0; // see RL11

   // every error that goes to the reset vector instead of a handler
   always_comb
   begin
      causeSet[CAUSE_WDT]     = wdtTimeout; // see RL8
      causeSet[CAUSE_UNINIT]  = uninitPointer; // see RL9
      causeSet[CAUSE_ILLEGAL] = illegalExec && !illegalFlushed; // see RL10
      causeSet[CAUSE_BROWN]   = brownout_reset;
      causeSet[CAUSE_LOCK]    = lockout;
   end

   // highest pending trap above the current level; traps ignore the nesting
   // disable and interrupt masks, only the level compare lets them nest
   always_comb
   begin
      trapFound = 1'b0;
      trapPick  = '0;
      for (int t = 0; t < NUM_TRAP; t++)
      begin
         if (st_ff.trapPend[t] && trapLevelOf(TRAP_IDX_W'(t)) > cpu_priority_level) // see RL12
         begin
            trapFound = 1'b1; // see RL17
            trapPick  = TRAP_IDX_W'(t);
         end
      end
   end

   // register read mux, nibble bit 3 always reads zero
   always_comb
   begin
      rdWord = '0;
      if (paddr < OFS_PRIO_END && paddr[BYTE_SHIFT-1:0] == '0)
      begin
         for (int i = 0; i < NUM_SRC; i++)
         begin
            if (wordIdx == itp_word_t'(i / NIB_PER_WORD))
            begin
               rdWord[(i % NIB_PER_WORD) * NIB_W +: PRIO_W] = st_ff.prio[i]; // see RL1
            end
         end
      end
      else if (paddr == OFS_CTRL)
      begin
         rdWord = DATA_W'(st_ff.ctrl);
      end
      else if (paddr == OFS_STATUS)
      begin
         rdWord = DATA_W'({st_ff.trapReq, st_ff.irqReq, st_ff.irqVector, st_ff.trapPend});
      end
      else if (paddr == OFS_CAUSE)
      begin
         rdWord = DATA_W'(st_ff.cause);
      end
   end

   // next-state logic for the whole block
   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.coreReset = 1'b0;
      nxt_st.pready    = 1'b0;
      nxt_st.pslverr   = 1'b0;

      // setup phase: answer in the first access cycle, read data
      // is taken from the registers as they stood at setup
      if (setupPhase)
      begin
         nxt_st.pready  = 1'b1;
         nxt_st.prdata  = rdWord;
         nxt_st.pslverr = !(paddr < OFS_PRIO_END || paddr == OFS_CTRL
                            || paddr == OFS_STATUS || paddr == OFS_CAUSE)
                          || paddr[BYTE_SHIFT-1:0] != '0;
      end

      // writes land at the completing access edge
      if (wrAccess)
      begin
         if (paddr < OFS_PRIO_END && paddr[BYTE_SHIFT-1:0] == '0)
         begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
               if (wordIdx == itp_word_t'(i / NIB_PER_WORD))
               begin
                  nxt_st.prio[i] = pwdata[(i % NIB_PER_WORD) * NIB_W +: PRIO_W]; // see RL2
               end
            end
         end
         else if (paddr == OFS_CTRL)
         begin
            nxt_st.ctrl = pwdata[CTL_W-1:0];
         end
         else if (paddr == OFS_CAUSE)
         begin
            nxt_st.cause = st_ff.cause & ~pwdata[CAUSE_W-1:0]; // write one to clear
         end
      end
      // a fresh cause sets even while software clears it
      nxt_st.cause = nxt_st.cause | causeSet;

      // table select is applied by the core to every fetch
      nxt_st.altTable = st_ff.ctrl[CTL_ALT_TBL]; // see RL25

      // trap pending bits: acknowledge first, new conditions win
      if (st_ff.trapReq && trapAck)
      begin
         nxt_st.trapPend[st_ff.trapIdx] = 1'b0;
         nxt_st.trapReq                 = 1'b0;
      end
      else if (!st_ff.trapReq && instrDone && trapFound)
      begin
         // present only at an instruction boundary, so the faulting
         // instruction has finished before the core vectors
         nxt_st.trapReq    = 1'b1; // see RL14
         nxt_st.trapIdx    = trapPick;
         nxt_st.trapLevel  = trapLevelOf(trapPick); // see RL15
         nxt_st.trapVector = TRAP_VEC_BASE + VEC_W'(trapPick);
      end
      if (!lockout)
      begin
         nxt_st.trapPend = nxt_st.trapPend | newTrap;
      end

      // interrupt request, always below any trap being presented;
      // level 7 or a trap level leaves no source able to pass
      nxt_st.irqReq = srcFound && !nestBlock && !st_ff.trapReq; // see RL16
      if (srcFound)
      begin
         nxt_st.irqVector = SRC_VEC_BASE + srcIdx; // see RL5
         nxt_st.irqLevel  = {1'b0, srcLevel}; // see RL4
      end

      // reset path bypasses vectoring; the core restarts at zero
      if (causeSet != '0)
      begin
         nxt_st.coreReset = 1'b1; // see RL7
         nxt_st.trapPend  = '0;
         nxt_st.trapReq   = 1'b0;
         nxt_st.irqReq    = 1'b0;
      end
   end

   // state register, everything clears to zero
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign prdata                 = st_ff.prdata;
   assign pready                 = st_ff.pready;
   assign pslverr                = st_ff.pslverr;
   assign irqReq                 = st_ff.irqReq;
   assign irqVector              = st_ff.irqVector;
   assign irqLevel               = st_ff.irqLevel;
   assign trapReq                = st_ff.trapReq;
   assign trapVector             = st_ff.trapVector;
   assign trapLevel              = st_ff.trapLevel;
   assign alternate_table_select = st_ff.altTable;
   assign coreReset              = st_ff.coreReset;

   // checks on the arbitration and trap paths
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_irq_vec_range: // see RL5
   assert property (irqReq |-> irqVector >= SRC_VEC_BASE
                    && !RESERVED_SRC[irqVector - SRC_VEC_BASE])
   else $error("interrupt vector outside the source table");
   a_irq_above_level: // see RL23
   assert property (irqReq |-> irqLevel > $past(cpu_priority_level))
   else $error("interrupt presented at or below the cpu level");
   a_prio_zero_quiet: // see RL22
   assert property (irqReq |-> irqLevel != '0 && !irqLevel[LVL_W-1])
   else $error("interrupt presented with level zero or trap level");
   a_nest_block_irq: // see RL24
   assert property (st_ff.ctrl[CTL_NEST_DIS] && inService |=> !irqReq)
   else $error("interrupt presented while nesting is disabled");
   a_lockout_reset: // see RL11
   assert property ($countones(newTrap) > 1 |=> coreReset
                    && st_ff.cause[CAUSE_LOCK])
   else $error("simultaneous traps did not reset");
   a_trap_level_top: // see RL15
   assert property (trapReq |-> trapLevel[LVL_W-1]
                    && (trapLevel > $past(cpu_priority_level) || $past(trapReq)))
   else $error("trap presented without trap level");
   a_trap_at_boundary: // see RL14
   assert property ($rose(trapReq) |-> $past(instrDone))
   else $error("trap presented before instruction completed");
   a_div_zero_trap: // see RL18
   assert property (divByZero && $countones(newTrap) == 1 && causeSet == '0
                    |=> st_ff.trapPend[TRAP_MATH])
   else $error("divide by zero did not post the math trap");
   a_uninit_reset: // see RL9
   assert property (uninitPointer |=> coreReset ##1 !coreReset || $past(causeSet != '0))
   else $error("uninitialised pointer did not reset");
   a_flushed_opcode: // see RL10
   assert property (illegalExec && illegalFlushed && causeSet == '0 |=> !coreReset)
   else $error("flushed illegal opcode caused a reset");
   a_trap_blocks_irq: // see RL12
   assert property (trapReq |=> !irqReq)
   else $error("interrupt presented alongside a trap");

endmodule : itp_prioritizer

`default_nettype wire

// [test/interrupt_trap_prioritizer_bench.sv]
// interrupt_trap_prioritizer_bench: self-checking bench for itp_prioritizer
// assumes itp_core_model as the core and an APB master in the bench
`timescale 1ns/100ps
`default_nettype none
module interrupt_trap_prioritizer_bench;
   import itp_pkg::*;
   logic               core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [ADDR_W-1:0]  paddr;
   logic [DATA_W-1:0]  pwdata, prdata, rd;
   logic [NUM_SRC-1:0] srcReq;
   logic [LVL_W-1:0]   lvlIn, cpu_priority_level, irqLevel, trapLevel;
   logic               svcIn, busy, ackOn, inService, instrDone, trapAck;
   logic               divByZero, guardBitsInUse, saturationOff, shiftTooFar;
   logic               addrError, badTrapVector, stackError, oscFail;
   logic [1:0]         accOvf31, accOvf39;
   logic               wdtTimeout, uninitPointer, illegalExec, illegalFlushed, brownout_reset;
   logic               irqReq, trapReq, alternate_table_select, coreReset;
   logic [VEC_W-1:0]   irqVector, trapVector;
   int                 mismatches = 0;
   int                 tests_run = 0;

   itp_prioritizer uut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .srcReq, .cpu_priority_level, .inService, .instrDone,
      .trapAck, .divByZero, .accOvf31, .guardBitsInUse, .accOvf39, .saturationOff,
      .shiftTooFar, .addrError, .badTrapVector, .stackError, .oscFail, .wdtTimeout,
      .uninitPointer, .illegalExec, .illegalFlushed, .brownout_reset, .irqReq, .irqVector,
      .irqLevel, .trapReq, .trapVector, .trapLevel, .alternate_table_select, .coreReset);
   itp_core_model core (.core_clk, .rst, .lvlIn, .svcIn, .busy, .ackOn, .trapReq,
      .cpu_priority_level, .inService, .instrDone, .trapAck);

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : settle

   // bounded wait for a pulse or level driven by the design
   task automatic waitSig(ref logic s);
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end while (s !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         print_verdict();
      end
      #1;
   endtask : waitSig

   // one APB transfer; pready is awaited, never assumed
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      apb(1'b0, a, '0);
      chk(rd, exp);
   endtask : rdChk

   task automatic irqChk(input logic [NUM_SRC-1:0] r, input logic [LVL_W-1:0] l,
                         input logic e, input logic [VEC_W-1:0] v, input logic [LVL_W-1:0] p);
      @(posedge core_clk);
      srcReq <= r;
      lvlIn <= l;
      settle(2);
      chk(irqReq, e);
      if (e)
      begin
         chk(irqVector, v);
         chk(irqLevel, p);
      end
   endtask : irqChk

   task automatic s_regs();
      rdChk(OFS_CTRL, 32'h0);
      rdChk(OFS_CAUSE, 32'h0);
      apb(1'b1, 8'h00, 32'hffff_ffff);
      rdChk(8'h00, 32'h7777_7777);
      apb(1'b1, 8'h2c, 32'h1);
      chk(err, 1'b1);
   endtask : s_regs

   task automatic s_irq();
      apb(1'b1, 8'h00, 32'h0000_5400);
      irqChk(54'h8, 4'h0, 1'b1, 6'h0b, 4'h5);
      irqChk(54'hc, 4'h0, 1'b1, 6'h0b, 4'h5);
      apb(1'b1, 8'h00, 32'h0000_4400);
      irqChk(54'hc, 4'h0, 1'b1, 6'h0a, 4'h4);
      irqChk(54'hc, 4'h4, 1'b0, 6'h0, 4'h0);
      irqChk(54'hc, 4'h3, 1'b1, 6'h0a, 4'h4);
      apb(1'b1, 8'h00, 32'h0);
      irqChk(54'hc, 4'h0, 1'b0, 6'h0, 4'h0);
      apb(1'b1, 8'h10, 32'h7000_0000);
      apb(1'b1, 8'h14, 32'h0000_7700);
      irqChk(54'h80_0000_0000, 4'h0, 1'b0, 6'h0, 4'h0);
      irqChk(54'h800_0000_0000, 4'h0, 1'b0, 6'h0, 4'h0);
      irqChk(54'h400_0000_0000, 4'h0, 1'b1, 6'h32, 4'h7);
      irqChk(54'h400_0000_0000, 4'h7, 1'b0, 6'h0, 4'h0);
      apb(1'b1, OFS_CTRL, 32'h1);
      svcIn <= 1'b1;
      irqChk(54'h400_0000_0000, 4'h0, 1'b0, 6'h0, 4'h0);
      @(posedge core_clk);
      svcIn <= 1'b0;
      apb(1'b1, OFS_CTRL, 32'h2);
      irqChk(54'h400_0000_0000, 4'h0, 1'b1, 6'h32, 4'h7);
      chk(alternate_table_select, 1'b1);
      irqChk(54'h0, 4'h7, 1'b0, 6'h0, 4'h0);
   endtask : s_irq

   // math conditions one by one, then bad vector, stack and oscillator faults
   task automatic s_traps();
      apb(1'b1, OFS_CTRL, 32'hc);
      for (int k = 0; k < 7; k++)
      begin
         @(posedge core_clk);
         busy <= (k == 0);
         {oscFail, stackError, badTrapVector, accOvf39[1], accOvf31[0],
          shiftTooFar, divByZero} <= 7'(1 << k);
         @(posedge core_clk);
         {oscFail, stackError, badTrapVector, accOvf39[1], accOvf31[0],
          shiftTooFar, divByZero} <= 7'h0;
         if (k == 0)
         begin
            settle(4);
            chk(trapReq, 1'b0);
            @(posedge core_clk);
            busy <= 1'b0;
         end
         waitSig(trapReq);
         chk(trapVector, (k < 4) ? 6'h01 : 6'(k - 2));
         chk(trapLevel, (k < 4) ? 4'hb : 4'(k + 8));
         chk(trapLevel[3], 1'b1);
         @(posedge core_clk);
         ackOn <= 1'b1;
         settle(3);
         chk(trapReq, 1'b0);
         @(posedge core_clk);
         ackOn <= 1'b0;
      end
      // guard bits in use hide a bit-31 overflow
      @(posedge core_clk);
      guardBitsInUse <= 1'b1;
      accOvf31 <= 2'b10;
      @(posedge core_clk);
      accOvf31 <= 2'b00;
      settle(3);
      chk(trapReq, 1'b0);
   endtask : s_traps

   task automatic s_resets();
      @(posedge core_clk);
      divByZero <= 1'b1;
      addrError <= 1'b1;
      @(posedge core_clk);
      divByZero <= 1'b0;
      addrError <= 1'b0;
      waitSig(coreReset);
      rdChk(OFS_CAUSE, 32'h10);
      chk(trapReq, 1'b0);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, OFS_CAUSE, 32'h1f);
         rdChk(OFS_CAUSE, 32'h0);
         if (i == 4)
            break;
         @(posedge core_clk);
         {brownout_reset, illegalExec, uninitPointer, wdtTimeout} <= 4'(1 << i);
         @(posedge core_clk);
         {brownout_reset, illegalExec, uninitPointer, wdtTimeout} <= 4'h0;
         waitSig(coreReset);
         rdChk(OFS_CAUSE, 32'(1 << i));
      end
      @(posedge core_clk);
      {illegalExec, illegalFlushed} <= 2'b11;
      @(posedge core_clk);
      {illegalExec, illegalFlushed} <= 2'b00;
      settle(3);
      rdChk(OFS_CAUSE, 32'h0);
   endtask : s_resets

   // main sequence; every input has a value at time zero
   initial
   begin
      {core_clk, psel, penable, pwrite, paddr, pwdata, srcReq, lvlIn, svcIn, busy} = '0;
      {ackOn, divByZero, guardBitsInUse, shiftTooFar, addrError, badTrapVector} = '0;
      {stackError, oscFail, accOvf31, accOvf39, wdtTimeout, uninitPointer} = '0;
      {illegalExec, illegalFlushed, brownout_reset} = '0;
      saturationOff = 1'b1;
      rst = 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      settle(1);
      chk({irqReq, trapReq, coreReset, alternate_table_select}, 4'h0);
      s_regs();
      s_irq();
      s_traps();
      s_resets();
      print_verdict();
   end
endmodule : interrupt_trap_prioritizer_bench
`default_nettype wire

// [test/itp_core_model.sv]
// itp_core_model: behavioural processor core facing the prioritizer
// assumes the bench steers level, service state, stalls and trap takes
`timescale 1ns/100ps
`default_nettype none
module itp_core_model
   import itp_pkg::*;
(
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // bench controls
   input  wire logic [itp_pkg::LVL_W-1:0] lvlIn,
   input  wire logic                      svcIn,
   input  wire logic                      busy,
   input  wire logic                      ackOn,
   // prioritizer side
   input  wire logic                      trapReq,
   output logic      [itp_pkg::LVL_W-1:0] cpu_priority_level,
   output logic                           inService,
   output logic                           instrDone,
   output logic                           trapAck
);
   // level and service state follow the bench
   assign cpu_priority_level = lvlIn;
   assign inService = svcIn;
   // a stalled instruction has not completed, so no trap may start yet
   assign instrDone = !busy;
   // one-cycle take of a presented trap; a restart forgets any take
   always_ff @(posedge core_clk)
   begin
      if (rst)
         trapAck <= 1'b0;
      else
         trapAck <= ackOn && trapReq && !trapAck;
   end
endmodule : itp_core_model
`default_nettype wire
